// [design/host_port_master.sv]
// Host end: drives one quadlet transfer per command from software
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module host_port_master
  import host_port_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  output logic             irq_out,
  host_port_if.host        pins
);
  typedef enum {S_IDLE, S_ALE, S_SETUP, S_STROBE, S_HOLD, S_DONE} state_t;
  state_t      state_reg;
  logic [3:0]  ctrl_reg;
  logic [7:0]  addr_reg;
  logic [31:0] wdata_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  lane_reg;
  logic [1:0]  stb_cnt_reg;
  logic [IRQ_BITS-1:0] irq_stat_reg;
  logic [IRQ_BITS-1:0] irq_en_reg;
  logic        done_ev;
  logic        last_lane;
  logic        wide;

  assign wide = ctrl_reg[CTRL_WIDE];
  assign last_lane = wide ? lane_reg[1] : (lane_reg == 2'h3);
  assign done_ev = (state_reg == S_DONE);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ctrl_reg <= 4'h0; addr_reg <= 8'h00; wdata_reg <= 32'h0; irq_en_reg <= '0;
    end else begin
      if (wr_in && addr_in == C_CTRL)   ctrl_reg   <= wdata_in[3:0];
      if (wr_in && addr_in == C_ADDR)   addr_reg   <= {wdata_in[5:0], 2'b00};
      if (wr_in && addr_in == C_WDATA)  wdata_reg  <= wdata_in;
      if (wr_in && addr_in == C_IRQ_EN) irq_en_reg <= wdata_in[IRQ_BITS-1:0];
      if (state_reg == S_DONE)          ctrl_reg[CTRL_GO] <= 1'b0;
    end
  end

  // Sticky events: set wins over software clear
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) irq_stat_reg <= '0;
    else irq_stat_reg <= (irq_stat_reg & ~((wr_in && addr_in == C_IRQ_CLR) ?
                          wdata_in[IRQ_BITS-1:0] : '0))
                         | {!pins.irq_level_n, done_ev};
  end
  assign irq_out = |(irq_stat_reg & irq_en_reg);

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_reg <= S_IDLE; lane_reg <= 2'h0; stb_cnt_reg <= 2'h0; rdata_reg <= 32'h0;
    end else begin
      case (state_reg)
        S_IDLE:   if (ctrl_reg[CTRL_GO]) begin
                    lane_reg  <= 2'h0;
                    state_reg <= ctrl_reg[CTRL_MUX] ? S_ALE : S_SETUP;
                  end
        S_ALE:    state_reg <= S_SETUP;
        S_SETUP:  begin stb_cnt_reg <= 2'h2; state_reg <= S_STROBE; end
        S_STROBE: if (!pins.host_wait_out) begin
                    if (stb_cnt_reg != 2'h0) stb_cnt_reg <= stb_cnt_reg - 2'h1;
                    else begin
                      if (wide) rdata_reg[16*lane_reg[1] +: 16] <= {pins.high_bus, pins.low_bus};
                      else      rdata_reg[8*lane_reg +: 8] <= pins.low_bus;
                      state_reg <= S_HOLD;
                    end
                  end
        S_HOLD:   if (!pins.host_wait_out) begin
                    if (last_lane) state_reg <= S_DONE;
                    else begin
                      lane_reg  <= lane_reg + (wide ? 2'h2 : 2'h1);
                      state_reg <= ctrl_reg[CTRL_MUX] ? S_ALE : S_SETUP;
                    end
                  end
        S_DONE:   state_reg <= S_IDLE;
        default:  state_reg <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) rdata_out <= 32'h0;
    else if (rd_in) case (addr_in)
      C_CTRL:     rdata_out <= {28'h0, ctrl_reg};
      C_ADDR:     rdata_out <= {26'h0, addr_reg[7:2]};
      C_WDATA:    rdata_out <= wdata_reg;
      C_RDATA:    rdata_out <= rdata_reg;
      C_STATUS:   rdata_out <= {30'h0, pins.host_wait_out, state_reg != S_IDLE};
      C_IRQ_STAT: rdata_out <= {30'h0, irq_stat_reg};
      C_IRQ_EN:   rdata_out <= {30'h0, irq_en_reg};
      default:    rdata_out <= 32'h0;
    endcase
  end

  logic act;
  logic wr_mode;
  assign act     = (state_reg == S_SETUP) || (state_reg == S_STROBE);
  assign wr_mode = ctrl_reg[CTRL_WRITE];
  assign pins.master_reset_n         = rst_b_in;
  assign pins.width_select_strap     = wide;
  assign pins.multiplex_select_strap = ctrl_reg[CTRL_MUX];
  assign pins.port_select_n          = !(act || state_reg == S_ALE || state_reg == S_HOLD);
  assign pins.address_latch_strobe   = (state_reg == S_ALE);
  assign pins.host_address_lines     = {addr_reg[7:2], lane_reg};
  assign pins.quadlet_boundary_bit   = wr_mode ? last_lane : (lane_reg == 2'h0);
  assign pins.write_strobe_n         = !(state_reg == S_STROBE && wr_mode);
  assign pins.read_strobe_n          = !(state_reg == S_STROBE && !wr_mode);
  assign pins.host_low_data_lines_h  = (state_reg == S_ALE) ? {addr_reg[7:2], lane_reg} :
                                       wdata_reg[8*lane_reg +: 8];
  assign pins.host_low_data_oe_h     = (state_reg == S_ALE) || (wr_mode && state_reg != S_IDLE);
  assign pins.host_high_data_lines_h = wdata_reg[8*lane_reg + 8 +: 8];
  assign pins.host_high_data_oe_h    = wide && wr_mode && act;
endmodule

// [shared/host_port_pkg.sv]
// Shared constants for the parallel host register port
package host_port_pkg;
  localparam int ADDR_W        = 8;
  localparam int BYTE_W        = 8;
  localparam int WORD_W        = 16;
  localparam int QUAD_W        = 32;
  localparam int REG_COUNT     = 16;
  localparam int REG_IDX_W     = 4;
  // Wait cycles the device holds the host off from a quadlet fetch or from the start of a quadlet's last write strobe
  localparam int QUAD_WAIT_CYC = 2;
  localparam logic [3:0] WAIT_CNT_W1 = 4'h1;
  // Controller register offsets
  localparam logic [3:0] C_CTRL     = 4'h0;
  localparam logic [3:0] C_ADDR     = 4'h1;
  localparam logic [3:0] C_WDATA    = 4'h2;
  localparam logic [3:0] C_RDATA    = 4'h3;
  localparam logic [3:0] C_STATUS   = 4'h4;
  localparam logic [3:0] C_IRQ_STAT = 4'h5;
  localparam logic [3:0] C_IRQ_CLR  = 4'h6;
  localparam logic [3:0] C_IRQ_EN   = 4'h7;
  // Controller control register bits
  localparam int CTRL_GO    = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_WIDE  = 2;
  localparam int CTRL_MUX   = 3;
  // Controller interrupt bits
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_DEV    = 1;
  localparam int IRQ_BITS   = 2;
  // Device interrupt register index and reset value
  localparam logic [3:0]  GEN_IRQ_IDX  = 4'hf;
  localparam logic [31:0] REG_RESET    = 32'h0000_0000;
endpackage

// [shared/host_port_if.sv]
// Interface carrying the host port pins between host and device
`timescale 1ns/10ps
interface host_port_if;
  logic [7:0] host_low_data_lines_h;
  logic       host_low_data_oe_h;
  logic [7:0] host_low_data_lines_d;
  logic       host_low_data_oe_d;
  logic [7:0] host_high_data_lines_h;
  logic       host_high_data_oe_h;
  logic [7:0] host_high_data_lines_d;
  logic       host_high_data_oe_d;
  logic [7:0] host_address_lines;
  logic       quadlet_boundary_bit;
  logic       port_select_n;
  logic       write_strobe_n;
  logic       read_strobe_n;
  logic       address_latch_strobe;
  logic       irq_out_n_oe;
  logic       host_wait_out;
  logic       master_reset_n;
  logic       width_select_strap;
  logic       multiplex_select_strap;
  // Resolved wire levels; open drain interrupt pulled high
  logic [7:0] low_bus;
  logic [7:0] high_bus;
  logic       irq_level_n;
  assign low_bus     = host_low_data_oe_d ? host_low_data_lines_d :
                       host_low_data_oe_h ? host_low_data_lines_h : 8'hff;
  assign high_bus    = host_high_data_oe_d ? host_high_data_lines_d :
                       host_high_data_oe_h ? host_high_data_lines_h : 8'hff;
  assign irq_level_n = ~irq_out_n_oe;
  modport device (
    input  low_bus, high_bus, host_address_lines, quadlet_boundary_bit, port_select_n,
    input  write_strobe_n, read_strobe_n, address_latch_strobe, master_reset_n,
    input  width_select_strap, multiplex_select_strap,
    output host_low_data_lines_d, host_low_data_oe_d, host_high_data_lines_d,
    output host_high_data_oe_d, irq_out_n_oe, host_wait_out
  );
  modport host (
    input  low_bus, high_bus, irq_level_n, host_wait_out,
    output host_low_data_lines_h, host_low_data_oe_h, host_high_data_lines_h,
    output host_high_data_oe_h, host_address_lines, quadlet_boundary_bit,
    output port_select_n, write_strobe_n, read_strobe_n, address_latch_strobe,
    output master_reset_n, width_select_strap, multiplex_select_strap
  );
endinterface

// [design/quadlet_stage.sv]
// Staging quadlet: gathers bytes or words and returns them by lane
`timescale 1ns/10ps
module quadlet_stage
  import host_port_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        clr_in,
  input  wire logic        wide_in,
  input  wire logic [1:0]  lane_in,
  input  wire logic        put_in,
  input  wire logic [15:0] put_data_in,
  input  wire logic        load_in,
  input  wire logic [31:0] load_data_in,
  output logic      [31:0] quad_out,
  output logic      [15:0] lane_data_out
);
  always_ff @(posedge clk_in or posedge clr_in) begin
    if (clr_in) begin
      quad_out <= REG_RESET;
    end else if (load_in) begin
      quad_out <= load_data_in;
    end else if (put_in) begin
      if (wide_in) begin
        if (lane_in[1]) quad_out[31:16] <= put_data_in;
        else            quad_out[15:0]  <= put_data_in;
      end else begin
        case (lane_in)
          2'h0:    quad_out[7:0]   <= put_data_in[7:0];
          2'h1:    quad_out[15:8]  <= put_data_in[7:0];
          2'h2:    quad_out[23:16] <= put_data_in[7:0];
          default: quad_out[31:24] <= put_data_in[7:0];
        endcase
      end
    end
  end

  always_comb begin
    if (wide_in) begin
      lane_data_out = lane_in[1] ? quad_out[31:16] : quad_out[15:0];
    end else begin
      case (lane_in)
        2'h0:    lane_data_out = {8'h00, quad_out[7:0]};
        2'h1:    lane_data_out = {8'h00, quad_out[15:8]};
        2'h2:    lane_data_out = {8'h00, quad_out[23:16]};
        default: lane_data_out = {8'h00, quad_out[31:24]};
      endcase
    end
  end
endmodule

// [design/host_register_port.sv]
// Device end of the parallel host register port
`timescale 1ns/10ps
module host_register_port
  import host_port_pkg::*;
(
  input  wire logic  clk_in,
  host_port_if.device pins,
  input  wire logic [IRQ_BITS-1:0] dev_irq_src_in,
  output logic      [31:0]         ctrl_reg_out,
  output logic                     irq_pending_out
);
  logic [31:0] regs [REG_COUNT];
  logic [7:0]  addr_latch_reg;
  logic [7:0]  addr;
  logic        rst;
  logic        wide;
  logic        mux;
  logic        sel;
  logic        wr_req;
  logic        rd_req;
  logic        wr_prev_reg;
  logic        rd_prev_reg;
  logic        wr_start;
  logic        rd_start;
  logic [3:0]  wait_cnt_reg;
  logic [31:0] quad;
  logic [15:0] lane_data;
  logic [15:0] put_data;
  logic [15:0] rd_data_reg;
  logic [3:0]  idx;

  assign rst  = ~pins.master_reset_n;
  assign wide = pins.width_select_strap;
  assign mux  = pins.multiplex_select_strap;
  assign sel  = ~pins.port_select_n;
  assign wr_req = sel && !pins.write_strobe_n;
  assign rd_req = sel && !pins.read_strobe_n && pins.write_strobe_n;
  assign addr = mux ? addr_latch_reg : pins.host_address_lines;
  assign idx  = addr[5:2];
  assign wr_start = wr_req && !wr_prev_reg;
  assign rd_start = rd_req && !rd_prev_reg;
  assign put_data = {wide ? pins.high_bus : 8'h00, pins.low_bus};

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or posedge rst) begin
    if (rst) begin
      wr_prev_reg  <= 1'b0;
      rd_prev_reg  <= 1'b0;
    end else begin
      wr_prev_reg  <= wr_req;
      rd_prev_reg  <= rd_req;
    end
  end

  // Address tracked while latch strobe is high, so the value at its fall is kept;
  // sampling after the fall would catch the lines already turned to data
  always_ff @(posedge clk_in or posedge rst) begin
    if (rst) begin
      addr_latch_reg <= 8'h00;
    end else if (mux && pins.address_latch_strobe) begin
      addr_latch_reg <= pins.low_bus;
    end
  end

  quadlet_stage u_stage (
    .clk_in       (clk_in),
    .clr_in       (rst),
    .wide_in      (wide),
    .lane_in      (addr[1:0]),
    .put_in       (wr_start),
    .put_data_in  (put_data),
    .load_in      (rd_start && pins.quadlet_boundary_bit),
    .load_data_in (regs[idx]),
    .quad_out     (quad),
    .lane_data_out(lane_data)
  );

  // Register store on the last write of a quadlet; gathered lane merged in
  always_ff @(posedge clk_in or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < REG_COUNT; i++) regs[i] <= REG_RESET;
    end else begin
      regs[GEN_IRQ_IDX] <= regs[GEN_IRQ_IDX] | {{(32-IRQ_BITS){1'b0}}, dev_irq_src_in};
      if (wr_prev_reg && !wr_req && pins.quadlet_boundary_bit) begin
        if (idx == GEN_IRQ_IDX)
          regs[idx] <= (regs[idx] & ~quad) | {{(32-IRQ_BITS){1'b0}}, dev_irq_src_in};
        else
          regs[idx] <= quad;
      end
    end
  end

  // Wait asserted for a short hold-off from each quadlet fetch or from the start of a quadlet's last write strobe, before the store
  always_ff @(posedge clk_in or posedge rst) begin
    if (rst) begin
      wait_cnt_reg <= 4'h0;
    end else if (pins.quadlet_boundary_bit && (wr_start || rd_start)) begin
      wait_cnt_reg <= 4'(QUAD_WAIT_CYC);
    end else if (wait_cnt_reg != 4'h0) begin
      wait_cnt_reg <= wait_cnt_reg - WAIT_CNT_W1;
    end
  end

  always_ff @(posedge clk_in or posedge rst) begin
    if (rst) begin
      rd_data_reg <= 16'h0000;
    end else if (rd_req) begin
      rd_data_reg <= (rd_start && pins.quadlet_boundary_bit) ?
                     (wide ? (addr[1] ? regs[idx][31:16] : regs[idx][15:0]) :
                      {8'h00, regs[idx][8*addr[1:0] +: 8]}) : lane_data;
    end
  end

  assign pins.host_wait_out         = (wait_cnt_reg != 4'h0);
  assign pins.host_low_data_lines_d = rd_data_reg[7:0];
  assign pins.host_low_data_oe_d    = rd_req && rd_prev_reg;
  assign pins.host_high_data_lines_d = rd_data_reg[15:8];
  assign pins.host_high_data_oe_d   = rd_req && rd_prev_reg && wide;
  assign irq_pending_out            = |regs[GEN_IRQ_IDX];
  assign pins.irq_out_n_oe          = irq_pending_out;
  assign ctrl_reg_out               = regs[0];
endmodule

// [verif/host_port_props.sv]
// Concurrent checks on the host port pins between the two ends
`timescale 1ns/10ps
module host_port_props
  import host_port_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic master_reset_n,
  input  wire logic port_select_n,
  input  wire logic write_strobe_n,
  input  wire logic read_strobe_n,
  input  wire logic address_latch_strobe,
  input  wire logic multiplex_select_strap,
  input  wire logic width_select_strap,
  input  wire logic host_low_data_oe_d,
  input  wire logic host_low_data_oe_h,
  input  wire logic host_high_data_oe_d,
  input  wire logic host_high_data_oe_h,
  input  wire logic host_wait_out,
  input  wire logic irq_out_n_oe
);
  localparam int WAIT_MAX = QUAD_WAIT_CYC + 2;
  logic read_req;
  logic any_strobe;

  assign read_req   = !port_select_n && !read_strobe_n && write_strobe_n;
  assign any_strobe = !read_strobe_n || !write_strobe_n;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!master_reset_n);

  ////////////////////////////////////////////////////////////////////////////////
  // Wait must fall again within a short bound once raised
  sequence wait_release;
    ##[1:WAIT_MAX] !host_wait_out;
  endsequence
  sequence strobes_held;
    $stable(read_strobe_n) && $stable(write_strobe_n);
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  a_dev_drives_read: assert property (host_low_data_oe_d |-> read_req || $past(read_req))
    else $error("device drives low lines outside a read");
  a_both_low_write: assert property ((!port_select_n && !write_strobe_n) |-> !host_low_data_oe_d)
    else $error("device drives data during a write cycle");
  a_dev_high_wide: assert property (host_high_data_oe_d |-> width_select_strap)
    else $error("device drives upper byte in 8-bit mode");
  a_host_high_wide: assert property (host_high_data_oe_h |-> width_select_strap)
    else $error("host drives upper byte in 8-bit mode");
  a_no_contention: assert property (!(host_low_data_oe_d && host_low_data_oe_h))
    else $error("both ends drive the low lines");
  a_latch_mux_only: assert property (address_latch_strobe |-> multiplex_select_strap)
    else $error("latch strobe used outside multiplex mode");
  a_strobe_selected: assert property (any_strobe |-> !port_select_n)
    else $error("strobe without select");
  a_wait_bounded: assert property ($rose(host_wait_out) |-> wait_release)
    else $error("wait held too long");
  a_wait_holds_off: assert property (host_wait_out && !port_select_n |=> strobes_held)
    else $error("host changed strobes during wait");
  a_reset_quiet: assert property (disable iff (1'b0)
    !master_reset_n |-> !host_low_data_oe_d && !irq_out_n_oe && !host_wait_out)
    else $error("device outputs active during reset");
endmodule

// [verif/host_register_port_test.sv]
// Self-checking bench joining the host and device ends of the host port
`timescale 1ns/10ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin failures++; \
  $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module host_register_port_test import host_port_pkg::*;;
  localparam int LIMIT = 20000;
  logic                clk_in;
  logic                rst_b_in;
  logic                wr_in;
  logic                rd_in;
  logic [3:0]          addr_in;
  logic [31:0]         wdata_in;
  logic [31:0]         rdata_out;
  logic [31:0]         ctrl_reg_out;
  logic [31:0]         rv;
  logic [31:0]         keep;
  logic                irq_out;
  logic                irq_pending_out;
  logic [IRQ_BITS-1:0] dev_irq_src_in;
  logic [3:0]          rst_tbl [3] = '{C_CTRL, C_STATUS, C_IRQ_STAT};
  int                  failures;
  int                  checks;
  int                  cyc;

  host_port_if pins_if ();
  host_port_master host_port_master_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .irq_out(irq_out), .pins(pins_if.host));
  host_register_port host_register_port_inst (.clk_in(clk_in), .pins(pins_if.device),
    .dev_irq_src_in(dev_irq_src_in), .ctrl_reg_out(ctrl_reg_out),
    .irq_pending_out(irq_pending_out));
  host_port_props host_port_props_inst (.clk_in(clk_in),
    .master_reset_n(pins_if.master_reset_n), .port_select_n(pins_if.port_select_n),
    .write_strobe_n(pins_if.write_strobe_n), .read_strobe_n(pins_if.read_strobe_n),
    .address_latch_strobe(pins_if.address_latch_strobe),
    .multiplex_select_strap(pins_if.multiplex_select_strap),
    .width_select_strap(pins_if.width_select_strap),
    .host_low_data_oe_d(pins_if.host_low_data_oe_d),
    .host_low_data_oe_h(pins_if.host_low_data_oe_h),
    .host_high_data_oe_d(pins_if.host_high_data_oe_d),
    .host_high_data_oe_h(pins_if.host_high_data_oe_h),
    .host_wait_out(pins_if.host_wait_out), .irq_out_n_oe(pins_if.irq_out_n_oe));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == LIMIT) begin
      failures++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
    #1;
  endtask

  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1;
    d = rdata_out;
  endtask

  // One quadlet transfer; m[1] selects multiplex, m[0] selects 16-bit lanes
  task automatic xfer(input logic [3:0] q, input logic w, input logic [1:0] m,
                      input logic [31:0] d);
    logic [31:0] s;
    int          n;
    wreg(C_ADDR, {28'h0, q});
    if (w) wreg(C_WDATA, d);
    wreg(C_CTRL, {28'h0, m, w, 1'b1});
    s = 32'h1;
    n = 0;
    while (s[0] === 1'b1 && n < 200) begin
      rreg(C_STATUS, s);
      n++;
    end
    `CHK(s[0], 1'b0)
    rreg(C_CTRL, s);
    `CHK(s, {28'h0, m, w, 1'b0})
    `CHK(irq_out, 1'b1)
    wreg(C_IRQ_CLR, 32'h1);
    `CHK(irq_out, 1'b0)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b_in       = 1'b0;
    wr_in          = 1'b0;
    rd_in          = 1'b0;
    addr_in        = 4'h0;
    wdata_in       = 32'h0;
    dev_irq_src_in = '0;
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    foreach (rst_tbl[i]) begin
      rreg(rst_tbl[i], rv);
      `CHK(rv, 32'h0)
    end
    `CHK(pins_if.irq_level_n, 1'b1)
    `CHK(pins_if.host_wait_out, 1'b0)
    wreg(C_IRQ_EN, 32'h1);
    // Write in each mode, read back in the opposite mode
    for (int m = 0; m < 4; m++) begin
      keep = 32'h8421_c3a5 ^ {8{4'(m)}};
      xfer(4'(m + 1), 1'b1, 2'(m), keep);
      xfer(4'(m + 1), 1'b0, 2'(3 - m), 32'h0);
      rreg(C_RDATA, rv);
      `CHK(rv, keep)
    end
    xfer(4'h0, 1'b1, 2'b00, 32'h5a3c_0f96);
    `CHK(ctrl_reg_out, 32'h5a3c_0f96)
    // Device event: pending, masked, enabled, cleared
    @(posedge clk_in);
    dev_irq_src_in <= 2'b01;
    @(posedge clk_in);
    dev_irq_src_in <= 2'b00;
    repeat (3) @(posedge clk_in);
    `CHK(irq_pending_out, 1'b1)
    `CHK(pins_if.irq_level_n, 1'b0)
    rreg(C_IRQ_STAT, rv);
    `CHK(rv[1], 1'b1)
    `CHK(irq_out, 1'b0)
    wreg(C_IRQ_EN, 32'h3);
    `CHK(irq_out, 1'b1)
    wreg(C_IRQ_EN, 32'h1);
    xfer(GEN_IRQ_IDX, 1'b0, 2'b11, 32'h0);
    rreg(C_RDATA, rv);
    `CHK(rv, 32'h1)
    xfer(GEN_IRQ_IDX, 1'b1, 2'b10, 32'h3);
    `CHK(irq_pending_out, 1'b0)
    `CHK(pins_if.irq_level_n, 1'b1)
    wreg(C_IRQ_CLR, 32'h2);
    rreg(C_IRQ_STAT, rv);
    `CHK(rv, 32'h0)
    // A write to an unmapped place leaves the control register alone
    rreg(C_CTRL, keep);
    wreg(4'hc, 32'hffff_ffff);
    rreg(C_CTRL, rv);
    `CHK(rv, keep)
    finish_test();
  end
endmodule
